// [eas_sequencer.sv]
// Operation
// - each step index pairs one stored event selection with one stored action selection.
// - when the current step's event is true its action is issued and the next step follows.
// - only the event of the current step is evaluated in each scan interval.
// - a false current event issues nothing and leaves the step unchanged.
// - on starting the sequencer evaluates step one every scan until it is true.
// - the number of programmed steps runs from zero to twenty.
// - after the last programmed step the sequencer returns to step one.
// - action codes are 1 none, 10 preset zero, 11 preset one and 29 start timer zero.
// - timer zero runs a programmable duration and its expiry makes its timeout event true.
`timescale 1ns/1ps
`default_nettype none
module eas_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire eas_pkg::eas_avm_req_t avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire logic speed_on_reference,
  output logic action_valid,
  output logic [7:0] action_code,
  output logic [7:0] preset_select,
  output logic timer0_running,
  output logic timer0_timeout,
  output logic [4:0] current_step,
  output logic sequencer_active
);
  localparam int unsigned N = eas_pkg::MAX_STEPS;
  logic [7:0] step_event_select [N];
  logic [7:0] step_action_select [N];
  logic sequencer_enable_mode, next_sequencer_enable_mode;
  logic [4:0] step_count, next_step_count;
  logic [31:0] sequencer_timer, next_sequencer_timer;
  logic [31:0] scan_len, next_scan_len;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic wr_hit;
  eas_pkg::eas_state_t state, next_state;
  logic [4:0] step, next_step;
  logic [31:0] scan_cnt, next_scan_cnt;
  logic [31:0] tmr_cnt, next_tmr_cnt;
  logic next_running, next_timeout, next_valid;
  logic [7:0] next_code, next_preset;
  logic [4:0] eff_count;
  logic ev_now, tick, fire, last;
  assign wr_hit = ce && avm_req.write && !avm_waitrequest;
  // per-entry storage of the paired selections
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_entry
      logic [7:0] next_ev, next_act;
      always_comb begin
        next_ev = step_event_select[gi];
        next_act = step_action_select[gi];
        if (wr_hit && avm_req.address == eas_pkg::ADDR_EVENT_BASE + 8'(4 * gi)) begin
          next_ev = avm_req.writedata[7:0];
        end
        if (wr_hit && avm_req.address == eas_pkg::ADDR_ACTION_BASE + 8'(4 * gi)) begin
          next_act = avm_req.writedata[7:0];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          step_event_select[gi] <= eas_pkg::EVENT_RESET;
          step_action_select[gi] <= eas_pkg::ACTION_RESET;
        end else if (ce) begin
          step_event_select[gi] <= next_ev;
          step_action_select[gi] <= next_act;
        end
      end
    end
  endgenerate
  // register bus: one wait cycle, then the answer
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avm_readdata;
    next_sequencer_enable_mode = sequencer_enable_mode;
    next_step_count = step_count;
    next_sequencer_timer = sequencer_timer;
    next_scan_len = scan_len;
    if ((avm_req.read || avm_req.write) && avm_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (avm_req.read) begin
        unique case (avm_req.address) inside
          eas_pkg::ADDR_CTRL: begin
            next_readdata[eas_pkg::CTRL_ENABLE_BIT] = sequencer_enable_mode;
            next_readdata[eas_pkg::CTRL_COUNT_LSB +: 5] = step_count;
          end
          eas_pkg::ADDR_STATUS: begin
            next_readdata = {8'h00, preset_select, 6'h00, timer0_timeout, timer0_running,
                             3'h0, step};
          end
          eas_pkg::ADDR_TIMER0: next_readdata = sequencer_timer;
          eas_pkg::ADDR_SCAN: next_readdata = scan_len;
          default: begin
            for (int i = 0; i < N; i++) begin
              if (avm_req.address == eas_pkg::ADDR_EVENT_BASE + 8'(4 * i)) begin
                next_readdata = {24'h000000, step_event_select[i]};
              end
              if (avm_req.address == eas_pkg::ADDR_ACTION_BASE + 8'(4 * i)) begin
                next_readdata = {24'h000000, step_action_select[i]};
              end
            end
          end
        endcase
      end
    end
    if (wr_hit) begin
      unique case (avm_req.address) inside
        eas_pkg::ADDR_CTRL: begin
          next_sequencer_enable_mode = avm_req.writedata[eas_pkg::CTRL_ENABLE_BIT];
          next_step_count = avm_req.writedata[eas_pkg::CTRL_COUNT_LSB +: 5];
        end
        eas_pkg::ADDR_TIMER0: next_sequencer_timer = avm_req.writedata;
        eas_pkg::ADDR_SCAN: next_scan_len = avm_req.writedata;
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avm_waitrequest <= 1'b1;
      avm_readdata <= 32'h0000_0000;
      sequencer_enable_mode <= 1'b0;
      step_count <= 5'h00;
      sequencer_timer <= eas_pkg::TIMER0_RESET;
      scan_len <= eas_pkg::SCAN_RESET;
    end else if (ce) begin
      avm_waitrequest <= next_waitrequest;
      avm_readdata <= next_readdata;
      sequencer_enable_mode <= next_sequencer_enable_mode;
      step_count <= next_step_count;
      sequencer_timer <= next_sequencer_timer;
      scan_len <= next_scan_len;
    end
  end
  // event evaluation: only the current step's selection is decoded
  always_comb begin
    unique case (step_event_select[step]) inside
      eas_pkg::EV_TRUE: ev_now = 1'b1;
      eas_pkg::EV_ON_REF: ev_now = speed_on_reference;
      eas_pkg::EV_TIMEOUT0: ev_now = timer0_timeout;
      default: ev_now = 1'b0;
    endcase
  end
  assign eff_count = (step_count > 5'(N)) ? 5'(N) : step_count;
  assign tick = (scan_cnt == 32'h0000_0000);
  assign fire = ce && tick && state == eas_pkg::EAS_RUN && sequencer_enable_mode &&
                eff_count != 5'h00 && ev_now;
  assign last = (step + 5'h01 >= eff_count);
  // sequencer, scan interval and timer zero
  always_comb begin
    next_state = state;
    next_step = step;
    next_scan_cnt = tick ? scan_len : scan_cnt - 32'h0000_0001;
    next_tmr_cnt = tmr_cnt;
    next_running = timer0_running;
    next_timeout = timer0_timeout;
    next_valid = 1'b0;
    next_code = action_code;
    next_preset = preset_select;
    if (timer0_running) begin
      if (tmr_cnt <= 32'h0000_0001) begin
        next_running = 1'b0;
        next_timeout = 1'b1;
      end else begin
        next_tmr_cnt = tmr_cnt - 32'h0000_0001;
      end
    end
    unique case (state)
      eas_pkg::EAS_IDLE: begin
        next_step = 5'h00;
        if (sequencer_enable_mode) begin
          next_state = eas_pkg::EAS_RUN;
        end
      end
      eas_pkg::EAS_RUN: begin
        if (!sequencer_enable_mode) begin
          next_state = eas_pkg::EAS_IDLE;
          next_step = 5'h00;
        end else if (fire) begin
          next_valid = 1'b1;
          next_code = step_action_select[step];
          next_step = last ? 5'h00 : step + 5'h01;
          unique case (step_action_select[step]) inside
            eas_pkg::ACT_PRESET0: next_preset = 8'h00;
            eas_pkg::ACT_PRESET1: next_preset = 8'h01;
            eas_pkg::ACT_TIMER0: begin
              next_tmr_cnt = sequencer_timer;
              next_running = sequencer_timer != 32'h0000_0000;
              next_timeout = sequencer_timer == 32'h0000_0000;
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= eas_pkg::EAS_IDLE;
      step <= 5'h00;
      scan_cnt <= 32'h0000_0000;
      tmr_cnt <= 32'h0000_0000;
      timer0_running <= 1'b0;
      timer0_timeout <= 1'b0;
      action_valid <= 1'b0;
      action_code <= eas_pkg::ACT_NONE;
      preset_select <= 8'h00;
      current_step <= 5'h00;
      sequencer_active <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      step <= next_step;
      scan_cnt <= next_scan_cnt;
      tmr_cnt <= next_tmr_cnt;
      timer0_running <= next_running;
      timer0_timeout <= next_timeout;
      action_valid <= next_valid;
      action_code <= next_code;
      preset_select <= next_preset;
      current_step <= next_step;
      sequencer_active <= next_state == eas_pkg::EAS_RUN;
    end
  end
  property p_step_range;
    @(posedge clk) disable iff (rst) step < 5'(N);
  endproperty
  a_step_range: assert property (p_step_range) else $error("step out of range");
  property p_fire_cause;
    @(posedge clk) disable iff (rst) action_valid && $past(ce) |-> $past(fire);
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("action without true event");
  property p_false_holds;
    @(posedge clk) disable iff (rst)
      ce && !fire && sequencer_enable_mode && state == eas_pkg::EAS_RUN |=> $stable(step);
  endproperty
  a_false_holds: assert property (p_false_holds) else $error("step moved on false");
  property p_no_act_false;
    @(posedge clk) disable iff (rst) ce && tick && !ev_now |=> !action_valid;
  endproperty
  a_no_act_false: assert property (p_no_act_false) else $error("action on false event");
  property p_code_pair;
    @(posedge clk) disable iff (rst) fire |=> action_code == $past(step_action_select[step]);
  endproperty
  a_code_pair: assert property (p_code_pair) else $error("action not paired");
  property p_wrap;
    @(posedge clk) disable iff (rst) fire && last |=> step == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap after last step");
  property p_advance;
    @(posedge clk) disable iff (rst) fire && !last |=> step == $past(step) + 5'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("no advance");
  property p_off_reset;
    @(posedge clk) disable iff (rst)
      ce && !sequencer_enable_mode |=> step == 5'h00 && !action_valid;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("mode off not honoured");
  property p_timer_start;
    @(posedge clk) disable iff (rst)
      fire && step_action_select[step] == eas_pkg::ACT_TIMER0 |=> !timer0_timeout || tmr_cnt == 0;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer not restarted");
  property p_bus_one;
    @(posedge clk) disable iff (rst) ce && !avm_waitrequest |=> avm_waitrequest;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("waitrequest low too long");
endmodule // eas_sequencer
`default_nettype wire

// [eas_pkg.sv]
`default_nettype none
package eas_pkg;
  localparam int unsigned MAX_STEPS = 20;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TIMER0_DEFAULT_MS = 2000;
  localparam logic [31:0] TIMER0_RESET = 32'(TIMER0_DEFAULT_MS * (CLK_HZ / 1000));
  localparam logic [31:0] SCAN_RESET = 32'h0000_C350;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIMER0 = 8'h08;
  localparam logic [7:0] ADDR_SCAN = 8'h0C;
  localparam logic [7:0] ADDR_EVENT_BASE = 8'h40;
  localparam logic [7:0] ADDR_ACTION_BASE = 8'hA0;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_COUNT_LSB = 8;
  localparam logic [7:0] EV_FALSE = 8'h00;
  localparam logic [7:0] EV_TRUE = 8'h01;
  localparam logic [7:0] EV_ON_REF = 8'h04;
  localparam logic [7:0] EV_TIMEOUT0 = 8'h1E;
  localparam logic [7:0] ACT_NONE = 8'h01;
  localparam logic [7:0] ACT_PRESET0 = 8'h0A;
  localparam logic [7:0] ACT_PRESET1 = 8'h0B;
  localparam logic [7:0] ACT_TIMER0 = 8'h1D;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] ACTION_RESET = 8'h01;
  typedef enum logic [1:0] {
    EAS_IDLE = 2'b00,
    EAS_RUN = 2'b01
  } eas_state_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } eas_avm_req_t;
endpackage
`default_nettype wire

// [eas_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eas_drive_model #(
  parameter int DELAY = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic action_valid,
  input wire logic [7:0] action_code,
  output logic speed_on_reference
);
  int cnt;
  logic new_ref;
  assign new_ref = action_valid && (action_code == eas_pkg::ACT_PRESET0 ||
                                    action_code == eas_pkg::ACT_PRESET1);
  // speed leaves reference on a new preset and reaches it after a delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      speed_on_reference <= 1'b0;
    end else if (new_ref) begin
      cnt <= DELAY;
      speed_on_reference <= 1'b0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      speed_on_reference <= (cnt == 1);
    end
  end
endmodule // eas_drive_model
`default_nettype wire

// [event_action_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module event_action_sequencer_tb;
  logic clk, rst, ce, avm_waitrequest, speed_on_reference, action_valid;
  logic timer0_running, timer0_timeout, sequencer_active;
  logic [31:0] avm_readdata, q;
  logic [7:0] action_code, preset_select;
  logic [4:0] current_step;
  eas_pkg::eas_avm_req_t avm_req;
  int n_mismatch, total_checks, cyc;
  eas_sequencer eas_sequencer_inst (.clk(clk), .rst(rst), .ce(ce), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .speed_on_reference(speed_on_reference), .action_valid(action_valid),
    .action_code(action_code), .preset_select(preset_select),
    .timer0_running(timer0_running), .timer0_timeout(timer0_timeout),
    .current_step(current_step), .sequencer_active(sequencer_active));
  eas_drive_model eas_drive_model_inst (.clk(clk), .rst(rst), .action_valid(action_valid),
    .action_code(action_code), .speed_on_reference(speed_on_reference));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avm_req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge clk);
    while (avm_waitrequest !== 1'b0) @(posedge clk);
    q = avm_readdata;
    avm_req <= '0;
    @(posedge clk);
  endtask
  task automatic wait_act(input logic [7:0] exp);
    int n;
    n = 0;
    while (action_valid !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check({action_valid, action_code}, {1'b1, exp});
    @(posedge clk);
  endtask
  task automatic no_act(input int cycles, input logic [4:0] step);
    int p;
    p = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (action_valid !== 1'b0) p++;
    end
    check(p, 0);
    check(current_step, step);
  endtask
  task automatic t_reset_regs();
    bus(0, eas_pkg::ADDR_TIMER0, 0);
    check(q, eas_pkg::TIMER0_RESET);
    bus(0, eas_pkg::ADDR_SCAN, 0);
    check(q, eas_pkg::SCAN_RESET);
    bus(0, eas_pkg::ADDR_EVENT_BASE + 8'h4C, 0);
    check(q, {24'h0, eas_pkg::EVENT_RESET});
    bus(0, eas_pkg::ADDR_ACTION_BASE, 0);
    check(q, {24'h0, eas_pkg::ACTION_RESET});
    bus(1, 8'h30, 32'hFFFF_FFFF);
    bus(0, 8'h30, 0);
    check(q, 32'h0);
  endtask
  task automatic t_example();
    logic [7:0] ev [4];
    logic [7:0] ac [4];
    ev = '{eas_pkg::EV_TRUE, eas_pkg::EV_ON_REF, eas_pkg::EV_TIMEOUT0, eas_pkg::EV_FALSE};
    ac = '{eas_pkg::ACT_PRESET0, eas_pkg::ACT_TIMER0, eas_pkg::ACT_PRESET1, eas_pkg::ACT_NONE};
    bus(1, eas_pkg::ADDR_SCAN, 32'h3);
    // the scan counter takes the new interval only at its next reload
    repeat (50010) @(posedge clk);
    bus(1, eas_pkg::ADDR_TIMER0, 32'h5);
    for (int i = 0; i < 4; i++) begin
      bus(1, eas_pkg::ADDR_EVENT_BASE + 8'(4 * i), {24'h0, ev[i]});
      bus(1, eas_pkg::ADDR_ACTION_BASE + 8'(4 * i), {24'h0, ac[i]});
    end
    bus(1, eas_pkg::ADDR_CTRL, 32'h0000_0401);
    wait_act(eas_pkg::ACT_PRESET0);
    check(preset_select, 8'h00);
    wait_act(eas_pkg::ACT_TIMER0);
    check(timer0_running, 1'b1);
    wait_act(eas_pkg::ACT_PRESET1);
    check({timer0_timeout, preset_select}, {1'b1, 8'h01});
    no_act(60, 5'd3);
    bus(0, eas_pkg::ADDR_STATUS, 0);
    check(q, 32'h0001_0203);
  endtask
  task automatic t_off_wrap_zero();
    bus(1, eas_pkg::ADDR_CTRL, 32'h0000_0400);
    no_act(30, 5'd0);
    check(sequencer_active, 1'b0);
    bus(1, eas_pkg::ADDR_CTRL, 32'h0000_0101);
    wait_act(eas_pkg::ACT_PRESET0);
    check(preset_select, 8'h00);
    check(current_step, 5'd0);
    wait_act(eas_pkg::ACT_PRESET0);
    bus(1, eas_pkg::ADDR_CTRL, 32'h0000_0001);
    no_act(40, 5'd0);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avm_req = '0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({action_valid, current_step}, 6'h0);
    t_reset_regs();
    t_example();
    t_off_wrap_zero();
    final_report();
  end
endmodule // event_action_sequencer_tb
`default_nettype wire
